// *** rtl/psp_consts.svh ***
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH

`define PSP_ADDR_W 19
`define PSP_DATA_W 36
`define PSP_LANES 4
`define PSP_LANE_W 9
`define PSP_CNT_W 2
`define PSP_CNT_ZERO 2'h0
`define PSP_CNT_ONE 2'h1
`define PSP_LANES_ALL 4'hf
`define PSP_LANES_NONE 4'h0
`define PSP_SYNC_IDLE 2'h0
`define PSP_ADDR_RST 19'h00000
`define PSP_DATA_RST 36'h000000000

`endif

// *** rtl/psp_pkg.sv ***
`include "psp_consts.svh"

package psp_pkg;

    typedef enum logic [1:0] {
        PSP_DESEL = 2'b00,
        PSP_ACTIVE = 2'b01,
        PSP_SLEEP = 2'b10
    } psp_state_t;

    // Synchronous control pins, all sampled on the rising clock edge
    typedef struct packed {
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_qualify_n;
        logic [`PSP_LANES-1:0] byte_lane_select_n;
        logic primary_chip_select_n;
        logic depth_select_high;
        logic depth_select_low_n;
    } psp_ctrl_t;

endpackage

// *** rtl/psp_port.sv ***
// Summary of operation
// (RULE_01) Capture address on a strobe only with all chip selects active.
// (RULE_02) Low two address bits load the burst counter on each capture.
// (RULE_03) A lane is written only if its select and the qualifier are low.
// (RULE_04) Global write low writes all bytes; lane selects are ignored.
// (RULE_05) Master drives the byte qualifier low for any byte-selective write.
// (RULE_06) Each edge with advance low increments the burst address; the code increments only in the active state on edges with no honoured strobe.
// (RULE_07) Selected only when first select low, second high, third low.
// (RULE_08) Chip selects are looked at only on edges that load a new address.
// (RULE_09) Processor strobe is ignored while the first chip select is high.
// (RULE_10) Either honoured strobe loads the address and the burst counter.
// (RULE_11) With both strobes low only the processor strobe is honoured.
// (RULE_12) Output enable low drives the data pins; high makes them inputs.
// (RULE_13) First read clock after deselect keeps data pins undriven.
// (RULE_14) Sleep high enters low-power state, contents kept; normally low.
// (RULE_15) Strap low selects linear burst order, high selects interleaved.
// (RULE_16) Burst counter wraps in two bits, covering four locations.
// (RULE_17) Read data on pins comes from the address of the preceding edge.
`timescale 1ns/10ps
`include "psp_consts.svh"

module psp_port
    import psp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [`PSP_ADDR_W-1:0] i_addr,
    input wire psp_ctrl_t i_ctrl,
    input wire logic i_output_enable_n,
    input wire logic i_sleep_request,
    input wire logic i_burst_mode,
    input wire logic [`PSP_DATA_W-1:0] i_dq,
    output logic [`PSP_DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic [`PSP_ADDR_W-1:0] o_mem_addr,
    output logic o_mem_rd,
    output logic [`PSP_LANES-1:0] o_mem_wr_en,
    output logic [`PSP_DATA_W-1:0] o_mem_wdata,
    input wire logic [`PSP_DATA_W-1:0] i_mem_rdata,
    output logic o_sleeping
);

////////////////////////////////////////////////////////////////////////////
    // Burst address low bits: linear adds, interleaved XORs the count
    function automatic logic [`PSP_CNT_W-1:0] burst_lsb(
        input logic [`PSP_CNT_W-1:0] start,
        input logic [`PSP_CNT_W-1:0] cnt,
        input logic linear
    );
        logic [`PSP_CNT_W-1:0] res;
        if (linear) begin
            res = start + cnt; // RULE_16
        end else begin
            res = start ^ cnt;
        end
        return res;
    endfunction

    // Lane enables for a write edge
    function automatic logic [`PSP_LANES-1:0] lane_mask(input psp_ctrl_t c);
        logic [`PSP_LANES-1:0] m;
        if (!c.global_write_n) begin
            m = `PSP_LANES_ALL; // RULE_04
        end else if (!c.byte_write_qualify_n) begin
            m = ~c.byte_lane_select_n; // RULE_03
        end else begin
            m = `PSP_LANES_NONE;
        end
        return m;
    endfunction

////////////////////////////////////////////////////////////////////////////
    // Asynchronous pins pass two flops; mode strap too, it is static
    logic [1:0] oe_sync;
    logic [1:0] sleep_sync;
    logic [1:0] mode_sync;
    logic [1:0] next_oe_sync;
    logic [1:0] next_sleep_sync;
    logic [1:0] next_mode_sync;

    always_comb begin
        next_oe_sync = {oe_sync[0], i_output_enable_n};
        next_sleep_sync = {sleep_sync[0], i_sleep_request};
        next_mode_sync = {mode_sync[0], i_burst_mode};
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            oe_sync <= ~`PSP_SYNC_IDLE;
            sleep_sync <= `PSP_SYNC_IDLE;
            mode_sync <= ~`PSP_SYNC_IDLE;
        end else begin
            oe_sync <= next_oe_sync;
            sleep_sync <= next_sleep_sync;
            mode_sync <= next_mode_sync;
        end
    end

    logic oe_n_s;
    logic sleep_s;
    logic linear_mode;
    assign oe_n_s = oe_sync[1];
    assign sleep_s = sleep_sync[1]; // RULE_14
    assign linear_mode = ~mode_sync[1]; // RULE_15

////////////////////////////////////////////////////////////////////////////
    // Access sequencing
    psp_state_t state;
    psp_state_t next_state;
    logic [`PSP_ADDR_W-1:0] base_addr;
    logic [`PSP_ADDR_W-1:0] next_base_addr;
    logic [`PSP_CNT_W-1:0] burst_cnt;
    logic [`PSP_CNT_W-1:0] next_burst_cnt;
    logic [`PSP_ADDR_W-1:0] next_mem_addr;
    logic next_mem_rd;
    logic [`PSP_LANES-1:0] next_mem_wr_en;
    logic [`PSP_DATA_W-1:0] next_mem_wdata;
    logic first_mask;
    logic next_first_mask;

    logic proc_hit;
    logic new_addr;
    logic cs_ok;
    logic access;
    logic [`PSP_LANES-1:0] wr_mask;

    always_comb begin
        // Processor strobe is dead while the first select is high
        proc_hit = ~i_ctrl.processor_addr_strobe_n
                 & ~i_ctrl.primary_chip_select_n; // RULE_09
        new_addr = proc_hit | ~i_ctrl.controller_addr_strobe_n; // RULE_10
        cs_ok = ~i_ctrl.primary_chip_select_n & i_ctrl.depth_select_high
              & ~i_ctrl.depth_select_low_n; // RULE_07
        wr_mask = lane_mask(i_ctrl);
        next_state = state;
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_mem_wdata = o_mem_wdata;
        next_mem_wr_en = `PSP_LANES_NONE;
        next_mem_rd = 1'b0;
        next_first_mask = 1'b0;
        access = 1'b0;
        if (sleep_s) begin
            next_state = PSP_SLEEP;
        end else if (state == PSP_SLEEP) begin
            next_state = PSP_DESEL;
        end else if (new_addr) begin
            // Selects count only here, never on internal burst edges
            if (cs_ok) begin // RULE_01 RULE_08
                next_state = PSP_ACTIVE;
                next_base_addr = i_addr; // RULE_10
                next_burst_cnt = `PSP_CNT_ZERO; // RULE_02
                access = 1'b1;
                next_first_mask = (state == PSP_DESEL); // RULE_13
                // A processor-strobe edge always opens as a read;
                // the controller strobe is not looked at then
                if (!proc_hit) begin // RULE_11
                    next_mem_wr_en = wr_mask;
                end
            end else begin
                next_state = PSP_DESEL;
            end
        end else if (state == PSP_ACTIVE) begin
            access = 1'b1;
            next_mem_wr_en = wr_mask;
            if (!i_ctrl.burst_advance_n) begin
                next_burst_cnt = burst_cnt + `PSP_CNT_ONE; // RULE_06 RULE_16
            end
        end
        if (next_mem_wr_en != `PSP_LANES_NONE) begin
            next_mem_wdata = i_dq;
        end
        next_mem_rd = access & (next_mem_wr_en == `PSP_LANES_NONE);
        next_mem_addr = {next_base_addr[`PSP_ADDR_W-1:`PSP_CNT_W],
            burst_lsb(next_base_addr[`PSP_CNT_W-1:0], next_burst_cnt,
                      linear_mode)}; // RULE_02
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state <= PSP_DESEL;
            base_addr <= `PSP_ADDR_RST;
            burst_cnt <= `PSP_CNT_ZERO;
            o_mem_addr <= `PSP_ADDR_RST;
            o_mem_rd <= 1'b0;
            o_mem_wr_en <= `PSP_LANES_NONE;
            o_mem_wdata <= `PSP_DATA_RST;
            first_mask <= 1'b0;
        end else begin
            state <= next_state;
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
            o_mem_addr <= next_mem_addr;
            o_mem_rd <= next_mem_rd;
            o_mem_wr_en <= next_mem_wr_en;
            o_mem_wdata <= next_mem_wdata;
            first_mask <= next_first_mask;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // Read output stage: one register after the array read
    logic [`PSP_DATA_W-1:0] next_dq;
    logic rd_valid;
    logic next_rd_valid;
    logic masked;
    logic next_masked;

    always_comb begin
        next_dq = o_dq;
        if (o_mem_rd) begin
            next_dq = i_mem_rdata; // RULE_17
        end
        next_rd_valid = o_mem_rd & ~sleep_s;
        next_masked = o_mem_rd & first_mask;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_dq <= `PSP_DATA_RST;
            rd_valid <= 1'b0;
            masked <= 1'b0;
        end else begin
            o_dq <= next_dq;
            rd_valid <= next_rd_valid;
            masked <= next_masked;
        end
    end

    // Drive only for a valid read word, never the masked first one
    assign o_dq_oe = ~oe_n_s & rd_valid & ~masked; // RULE_12 RULE_13
    assign o_sleeping = (state == PSP_SLEEP); // RULE_14

endmodule

// *** sim/psp_mem_model.sv ***
`timescale 1ns/10ps

module psp_mem_model (
    input wire logic i_core_clk,
    input wire logic [18:0] i_addr,
    input wire logic i_rd,
    input wire logic [3:0] i_wr_en,
    input wire logic [35:0] i_wdata,
    output logic [35:0] o_rdata
);
    logic [35:0] mem [16];
    logic [35:0] last;
    // Off-read the model shows the inverse of the last word read, so stale capture shows up
    always_comb o_rdata = i_rd ? mem[i_addr[3:0]] : ~last;
    always_ff @(posedge i_core_clk) begin
        if (i_rd)
            last <= mem[i_addr[3:0]];
        for (int k = 0; k < 4; k++)
            if (i_wr_en[k])
                mem[i_addr[3:0]][9*k+:9] <= i_wdata[9*k+:9];
    end
endmodule

// *** sim/psp_port_props.sv ***
`timescale 1ns/10ps

module psp_port_props
    import psp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [18:0] i_addr,
    input wire psp_ctrl_t i_ctrl,
    input wire logic i_sleep_request,
    input wire logic [35:0] i_dq,
    input wire logic [35:0] i_mem_rdata,
    input wire logic [35:0] o_dq,
    input wire logic [18:0] o_mem_addr,
    input wire logic o_mem_rd,
    input wire logic [3:0] o_mem_wr_en,
    input wire logic [35:0] o_mem_wdata,
    input wire logic o_sleeping
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic [2:0] slp_h;
    logic sel, ok, ps, cs, all_wr;
    always_ff @(posedge i_core_clk) slp_h <= {slp_h[1:0], i_sleep_request};
    // Sleep passes a synchroniser, so only judge edges well clear of it
    assign ok = slp_h == 3'h0 && !i_sleep_request && !o_sleeping;
    assign sel = !i_ctrl.primary_chip_select_n && i_ctrl.depth_select_high
        && !i_ctrl.depth_select_low_n;
    assign ps = !i_ctrl.processor_addr_strobe_n;
    assign cs = !i_ctrl.controller_addr_strobe_n;
    assign all_wr = !i_ctrl.global_write_n;
    capture_addr_a: assert property (ps && sel && ok
        |=> o_mem_rd && o_mem_addr == $past(i_addr)) else $error("no capture");
    desel_access_a: assert property (ok && !sel
        && (cs || ps && !i_ctrl.primary_chip_select_n)
        |=> !o_mem_rd && o_mem_wr_en == 4'h0) else $error("access desel");
    proc_ignored_a: assert property (ok && ps && !cs
        && i_ctrl.primary_chip_select_n && i_ctrl.burst_advance_n
        |=> $stable(o_mem_addr)) else $error("strobe not ignored");
    both_strobes_a: assert property (ps && cs && sel && all_wr && ok
        |=> o_mem_rd && o_mem_wr_en == 4'h0) else $error("both strobes");
    global_write_a: assert property (cs && !ps && sel
        && all_wr && ok
        |=> o_mem_wr_en == 4'hf && o_mem_wdata == $past(i_dq))
        else $error("global write");
    byte_write_a: assert property (cs && !ps && sel && !all_wr && ok
        |=> o_mem_wr_en == ($past(i_ctrl.byte_write_qualify_n) ? 4'h0
        : ~$past(i_ctrl.byte_lane_select_n))) else $error("byte write");
    burst_step_a: assert property (o_mem_rd
        && !ps && !cs && !all_wr && ok && !i_ctrl.burst_advance_n
        && i_ctrl.byte_write_qualify_n
        |=> o_mem_rd && o_mem_addr[18:2] == $past(o_mem_addr[18:2])
        && o_mem_addr[1:0] != $past(o_mem_addr[1:0])) else $error("advance");
    read_pipe_a: assert property (o_mem_rd
        |=> o_dq == $past(i_mem_rdata)) else $error("read pipe");
    sleep_enter_a: assert property (i_sleep_request [*4]
        |=> o_sleeping) else $error("no sleep");
endmodule

bind psp_port psp_port_props psp_port_props_inst (.i_core_clk, .i_rst_b,
    .i_addr, .i_ctrl, .i_sleep_request, .i_dq, .i_mem_rdata, .o_dq,
    .o_mem_addr, .o_mem_rd, .o_mem_wr_en, .o_mem_wdata, .o_sleeping);

// *** sim/tb.sv ***
`timescale 1ns/10ps

module tb;
    import psp_pkg::*;
    logic i_core_clk = 0, i_rst_b = 0, i_output_enable_n = 0;
    logic i_sleep_request = 0, i_burst_mode = 0, o_dq_oe, o_mem_rd, o_sleeping;
    logic [18:0] i_addr = 0, o_mem_addr, base;
    psp_ctrl_t i_ctrl = '1;
    logic [35:0] i_dq = 0, o_dq, o_mem_wdata, i_mem_rdata, mm [16], q [$];
    logic [3:0] o_mem_wr_en;
    logic [11:0] c;
    logic [63:0] r;
    logic oq [$];
    int failures = 0, check_count = 0, seed = 32'he34b5b12;
    int act = 0, cnt, asleep = 0;
    // Pin levels that cyc applies at its falling edge
    logic oe_cfg = 0, mode_cfg = 0;
    psp_port psp_port_inst (.i_core_clk, .i_rst_b, .i_addr, .i_ctrl,
        .i_output_enable_n, .i_sleep_request, .i_burst_mode, .i_dq, .o_dq,
        .o_dq_oe, .o_mem_addr, .o_mem_rd, .o_mem_wr_en, .o_mem_wdata,
        .i_mem_rdata, .o_sleeping);
    psp_mem_model psp_mem_model_inst (.i_core_clk, .i_addr(o_mem_addr),
        .i_rd(o_mem_rd), .i_wr_en(o_mem_wr_en), .i_wdata(o_mem_wdata),
        .o_rdata(i_mem_rdata));
    initial forever #25 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [35:0] s, input logic [35:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("failures=%0d check_count=%0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One bus cycle: drive at the falling edge, then predict and compare
    task cyc(input logic [11:0] k, input logic [18:0] a, input logic [35:0] d);
        logic [3:0] wr;
        logic [18:0] ea;
        logic first;
        @(negedge i_core_clk);
        i_ctrl = k;
        i_addr = a;
        i_dq = d;
        i_output_enable_n = oe_cfg;
        i_burst_mode = mode_cfg;
        @(posedge i_core_clk);
        #1;
        first = 0;
        wr = !k[8] ? 4'hf : (!k[7] ? ~k[6:3] : 4'h0);
        if (asleep)
            act = 0;
        else if ((!k[11] && !k[2]) || !k[10]) begin
            first = !act;
            act = !k[2] && k[1] && !k[0];
            base = a;
            cnt = 0;
            if (!k[11])
                wr = 0;
        end else if (act && !k[9])
            cnt++;
        ea = {base[18:2], i_burst_mode ? base[1:0] ^ cnt[1:0]
            : base[1:0] + cnt[1:0]};
        if (!act)
            wr = 0;
        if (q.size() > 0) begin
            chk(o_dq, q.pop_front());
            chk(o_dq_oe, oq.pop_front());
        end
        chk(o_mem_rd, act && wr == 0);
        chk(o_mem_wr_en, wr);
        if (act)
            chk(o_mem_addr, ea);
        if (wr != 0)
            chk(o_mem_wdata, d);
        for (int j = 0; j < 4; j++)
            if (wr[j])
                mm[ea[3:0]][9*j+:9] = d[9*j+:9];
        if (act && wr == 0) begin
            q.push_back(mm[ea[3:0]]);
            // Enable seen at this edge gates the word shown after the next
            oq.push_back(!first && !i_output_enable_n);
        end
    endtask
    initial begin
        #500000;
        failures++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk) i_rst_b = 1;
        repeat (3) cyc(12'hfff, 0, 0);
        for (int b = 0; b < 16; b += 4) begin
            cyc(12'hafa, b, {$random(seed), $random(seed)});
            repeat (3) cyc(12'hcfa, 0, {$random(seed), $random(seed)});
        end
        for (int m = 0; m < 2; m++) begin
            cyc(12'hbfe, 0, 0);
            mode_cfg = m[0];
            repeat (3) cyc(12'hfff, 0, 0);
            for (int s = 0; s < 4; s++) begin
                cyc(12'h7fa, s + 8, 0);
                repeat (4) cyc(12'hdfd, 0, 0);
            end
        end
        cyc(12'h7fe, 3, 0);
        cyc(12'h2fa, 5, 36'h5);
        cyc(12'hb2a, 6, 36'h123456789);
        cyc(12'hbaa, 6, 36'hfedcba987);
        cyc(12'h7fa, 6, 0);
        oe_cfg = 1;
        repeat (2) cyc(12'hdfd, 0, 0);
        oe_cfg = 0;
        repeat (400) begin
            r = {$random(seed), $random(seed)};
            c = r[11:0];
            oe_cfg = r[31];
            if (r[12])
                c[2:0] = 3'b010;
            cyc(c, r[30:12], r[63:28]);
        end
        oe_cfg = 0;
        cyc(12'hbfe, 0, 0);
        @(negedge i_core_clk) i_sleep_request = 1;
        repeat (4) cyc(12'hfff, 0, 0);
        chk(o_sleeping, 1);
        asleep = 1;
        cyc(12'h7fa, 1, 0);
        asleep = 0;
        @(negedge i_core_clk) i_sleep_request = 0;
        repeat (4) cyc(12'hfff, 0, 0);
        chk(o_sleeping, 0);
        cyc(12'h7fa, 2, 0);
        cyc(12'hfff, 0, 0);
        end_sim;
    end
endmodule
